// ===== logic/sisc_capture.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
module sisc_capture (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire sisc_pkg::sisc_events_t events,
  input  wire sisc_pkg::sisc_bus_req_t bus,
  output logic [15:0]                rdata_ff,
  output logic                       irq_ff
);
  import sisc_pkg::*;

  logic [15:0] level_ff;
  logic [15:0] nxt_level;
  logic [15:0] rise;
  logic [15:0] flags_ff;
  logic [15:0] nxt_flags;
  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic [15:0] mask_ff;
  logic [15:0] nxt_mask;
  logic [15:0] nxt_rdata;
  logic        nxt_irq;
  logic        flags_read;
  logic        status_read;
  logic        mask_read;
  logic        status_write;
  logic        mask_write;

  // bus decode shared by every register group; the master never raises both strobes
  always_comb begin
    flags_read   = bus.rd && (bus.addr == FLAGS_OFFSET);
    status_read  = bus.rd && (bus.addr == STATUS_OFFSET);
    mask_read    = bus.rd && (bus.addr == MASK_OFFSET);
    status_write = bus.wr && (bus.addr == STATUS_OFFSET);
    mask_write   = bus.wr && (bus.addr == MASK_OFFSET);
  end

  // one detector for all twelve sources; unused bit positions are held at zero
  always_comb begin
    nxt_level                 = 16'h0000;
    nxt_level[BIT_SINK_ONE]   = events.sink_one_regulation_lost;
    nxt_level[BIT_SINK_TWO]   = events.sink_two_regulation_lost;
    nxt_level[BIT_BUS_LIMIT]  = events.bus_power_limit_switch;
    nxt_level[BIT_AUX_READY]  = events.aux_converter_result_ready;
    nxt_level[BIT_AUX_COMP4]  = events.aux_comparator_four;
    nxt_level[BIT_AUX_COMP3]  = events.aux_comparator_three;
    nxt_level[BIT_AUX_COMP2]  = events.aux_comparator_two;
    nxt_level[BIT_AUX_COMP1]  = events.aux_comparator_one;
    nxt_level[BIT_SUPPLY_LOW] = events.supply_below_shutdown;
    nxt_level[BIT_DIE_WARM]   = events.die_warm_limit;
    nxt_level[BIT_DIE_HOT]    = events.die_hot_limit;
    nxt_level[BIT_WATCHDOG]   = events.watchdog_expiry;
    // a source already high at reset release counts as an edge in the first cycle
    rise = nxt_level & ~level_ff & FLAGS_USED;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_ff <= FLAGS_RESET;
    end else begin
      level_ff <= nxt_level;
    end
  end

  always_comb begin
    nxt_flags = flags_ff;
    if (flags_read) begin
      // the read returns every flag, so every flag is cleared
      nxt_flags = 16'h0000;
    end
    // set wins: an edge in the read cycle is kept for the next read
    nxt_flags = nxt_flags | rise;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_ff <= FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // separate copy for the interrupt line, so reading the flags does not drop irq
  always_comb begin
    nxt_status = status_ff;
    if (status_write) begin
      nxt_status = status_ff & ~bus.wdata;
    end
    nxt_status = nxt_status | rise;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_ff <= FLAGS_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_comb begin
    nxt_mask = mask_ff;
    if (mask_write) begin
      // unused positions stay zero so they read back as zero
      nxt_mask = bus.wdata & FLAGS_USED;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_ff <= MASK_RESET;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // read data stand for one cycle only; idle cycles return zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (bus.rd) begin
      unique case (bus.addr)
        FLAGS_OFFSET:  nxt_rdata = flags_ff;
        STATUS_OFFSET: nxt_rdata = status_ff;
        MASK_OFFSET:   nxt_rdata = mask_ff;
        default:       nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // built from the next values so irq follows status and mask with no extra delay
  always_comb begin
    nxt_irq = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  a_sink_one_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.sink_one_regulation_lost) |=> flags_ff[BIT_SINK_ONE])
    else $error("sink one edge not flagged");

  a_sink_two_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.sink_two_regulation_lost) |=> flags_ff[BIT_SINK_TWO])
    else $error("sink two edge not flagged");

  a_bus_limit_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.bus_power_limit_switch) |=> flags_ff[BIT_BUS_LIMIT])
    else $error("limit switch edge not flagged");

  a_supply_low_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.supply_below_shutdown) |=> flags_ff[BIT_SUPPLY_LOW])
    else $error("supply low edge not flagged");

  a_die_warm_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.die_warm_limit) |=> flags_ff[BIT_DIE_WARM])
    else $error("warm edge not flagged");

  a_die_hot_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.die_hot_limit) |=> flags_ff[BIT_DIE_HOT])
    else $error("hot edge not flagged");

  a_watchdog_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.watchdog_expiry) |=> flags_ff[BIT_WATCHDOG])
    else $error("watchdog edge not flagged");

  a_aux_ready_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.aux_converter_result_ready) |=> flags_ff[BIT_AUX_READY])
    else $error("converter ready edge not flagged");

  a_comp_four_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.aux_comparator_four) |=> flags_ff[BIT_AUX_COMP4])
    else $error("comparator four edge not flagged");

  a_comp_three_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.aux_comparator_three) |=> flags_ff[BIT_AUX_COMP3])
    else $error("comparator three edge not flagged");

  a_comp_two_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.aux_comparator_two) |=> flags_ff[BIT_AUX_COMP2])
    else $error("comparator two edge not flagged");

  a_comp_one_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(events.aux_comparator_one) |=> flags_ff[BIT_AUX_COMP1])
    else $error("comparator one edge not flagged");

  a_no_spurious_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=> (flags_ff & ~$past(flags_ff)) == ($past(rise) & ~$past(flags_ff)))
    else $error("flag set without an edge");

  a_flags_sticky: assert property (
    @(posedge sys_clk) disable iff (rst)
    !flags_read |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("flag lost without read");

  a_read_returns: assert property (
    @(posedge sys_clk) disable iff (rst)
    flags_read |=> rdata_ff == $past(flags_ff))
    else $error("read data wrong");

  a_read_clears: assert property (
    @(posedge sys_clk) disable iff (rst)
    flags_read |=> flags_ff == $past(rise))
    else $error("read did not clear flags");

  a_flags_no_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    (bus.wr && bus.addr == FLAGS_OFFSET) |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("write changed flags");

  a_unused_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    (flags_ff & ~FLAGS_USED) == 16'h0000)
    else $error("unused flag bit set");

  a_flags_after_reset: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(rst) |-> flags_ff == FLAGS_RESET)
    else $error("flags not cleared by reset");

  a_status_sticky: assert property (
    @(posedge sys_clk) disable iff (rst)
    !status_write |=> (status_ff & $past(status_ff)) == $past(status_ff))
    else $error("status lost without write");

  a_status_w1c: assert property (
    @(posedge sys_clk) disable iff (rst)
    status_write |=> (status_ff & $past(bus.wdata) & ~$past(rise)) == 16'h0000)
    else $error("status write one did not clear");

  a_status_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=> (status_ff & $past(rise)) == $past(rise))
    else $error("status missed an edge");

  a_status_unused: assert property (
    @(posedge sys_clk) disable iff (rst)
    (status_ff & ~FLAGS_USED) == 16'h0000)
    else $error("unused status bit set");

  a_mask_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    mask_write |=> mask_ff == ($past(bus.wdata) & FLAGS_USED))
    else $error("mask write wrong");

  a_mask_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !mask_write |=> $stable(mask_ff))
    else $error("mask changed without write");

  a_status_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    status_read |=> rdata_ff == $past(status_ff))
    else $error("status read data wrong");

  a_mask_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    mask_read |=> rdata_ff == $past(mask_ff))
    else $error("mask read data wrong");

  a_rdata_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    !bus.rd |=> rdata_ff == 16'h0000)
    else $error("read data outside read cycle");

  a_unmapped_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    (bus.rd && !flags_read && !status_read && !mask_read) |=> rdata_ff == 16'h0000)
    else $error("unmapped read not zero");

  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (rst)
    irq_ff == |(status_ff & mask_ff))
    else $error("irq does not follow status and mask");

  a_outputs_reset: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(rst) |-> (!irq_ff && rdata_ff == 16'h0000))
    else $error("outputs not cleared by reset");
endmodule // sisc_capture

// ===== logic/sisc_pkg.sv
package sisc_pkg;
  localparam int unsigned       REG_W            = 16;
  localparam int unsigned       ADDR_W           = 8;
  localparam logic [7:0]        FLAGS_OFFSET     = 8'h1A;
  localparam logic [7:0]        STATUS_OFFSET    = 8'h40;
  localparam logic [7:0]        MASK_OFFSET      = 8'h41;
  localparam logic [15:0]       FLAGS_RESET      = 16'h0000;
  localparam logic [15:0]       MASK_RESET       = 16'h0000;
  localparam logic [15:0]       FLAGS_USED       = 16'h35FF;
  localparam int unsigned       BIT_SINK_ONE     = 13;
  localparam int unsigned       BIT_SINK_TWO     = 12;
  localparam int unsigned       BIT_BUS_LIMIT    = 10;
  localparam int unsigned       BIT_AUX_READY    = 8;
  localparam int unsigned       BIT_AUX_COMP4    = 7;
  localparam int unsigned       BIT_AUX_COMP3    = 6;
  localparam int unsigned       BIT_AUX_COMP2    = 5;
  localparam int unsigned       BIT_AUX_COMP1    = 4;
  localparam int unsigned       BIT_SUPPLY_LOW   = 3;
  localparam int unsigned       BIT_DIE_WARM     = 2;
  localparam int unsigned       BIT_DIE_HOT      = 1;
  localparam int unsigned       BIT_WATCHDOG     = 0;

  typedef struct packed {
    logic sink_one_regulation_lost;
    logic sink_two_regulation_lost;
    logic bus_power_limit_switch;
    logic aux_converter_result_ready;
    logic aux_comparator_four;
    logic aux_comparator_three;
    logic aux_comparator_two;
    logic aux_comparator_one;
    logic supply_below_shutdown;
    logic die_warm_limit;
    logic die_hot_limit;
    logic watchdog_expiry;
  } sisc_events_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } sisc_bus_req_t;
endpackage

// ===== tb/sisc_event_src.sv
`timescale 1ns/1ns
module sisc_event_src
  import sisc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic [11:0]       level,
  output sisc_pkg::sisc_events_t events
);
  // monitors change only on the clock, so no edge can hide between samples
  always_ff @(posedge sys_clk) begin
    events <= level;
  end
endmodule // sisc_event_src

// ===== tb/sisc_capture_tb.sv
`timescale 1ns/1ns
module sisc_capture_tb;
  import sisc_pkg::*;
  localparam int map[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 12, 13};
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic [11:0]   level = 12'h000;
  sisc_events_t  events;
  sisc_bus_req_t bus = '0;
  logic [15:0]   rdata_ff;
  logic          irq_ff;
  int            fail_count = 0;
  int            total_checks = 0;
  int            cycles = 0;
  initial forever #5 sys_clk = ~sys_clk;
  sisc_event_src u_src (.sys_clk(sys_clk), .level(level), .events(events));
  sisc_capture u_dut (.sys_clk(sys_clk), .rst(rst), .events(events), .bus(bus),
    .rdata_ff(rdata_ff), .irq_ff(irq_ff));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) bus.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk) bus.rd <= 1'b0;
    #1 check(rdata_ff, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(FLAGS_OFFSET, FLAGS_RESET);
    rd(8'h7F, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk) level[i] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(FLAGS_OFFSET, 16'h0001 << map[i]);
      // level still high: a read must not see the flag again
      rd(FLAGS_OFFSET, 16'h0000);
      @(posedge sys_clk) level[i] <= 1'b0;
    end
    $display("test edge flags done");
    rd(STATUS_OFFSET, FLAGS_USED);
    check({15'h0000, irq_ff}, 16'h0000);
    wr(MASK_OFFSET, 16'h0001);
    @(posedge sys_clk);
    #1 check({15'h0000, irq_ff}, 16'h0001);
    wr(STATUS_OFFSET, 16'hFFFF);
    @(posedge sys_clk);
    #1 check({15'h0000, irq_ff}, 16'h0000);
    rd(STATUS_OFFSET, 16'h0000);
    $display("test interrupt done");
    // edge and read strobe in one cycle: the read misses it, the flag survives
    @(posedge sys_clk) level[0] <= 1'b1;
    rd(FLAGS_OFFSET, 16'h0000);
    wr(FLAGS_OFFSET, 16'hFFFF);
    rd(FLAGS_OFFSET, 16'h0001);
    @(posedge sys_clk);
    #1 check(rdata_ff, 16'h0000);
    @(posedge sys_clk) level[0] <= 1'b0;
    $display("test set wins done");
    @(posedge sys_clk) level[5] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    level[5] <= 1'b0;
    wr(MASK_OFFSET, 16'hFFFF);
    rd(MASK_OFFSET, FLAGS_USED);
    check({15'h0000, irq_ff}, 16'h0001);
    @(posedge sys_clk) rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(FLAGS_OFFSET, FLAGS_RESET);
    rd(MASK_OFFSET, MASK_RESET);
    check({15'h0000, irq_ff}, 16'h0000);
    $display("test reset again done");
    wrap_up();
  end
endmodule // sisc_capture_tb
